// [obp_pkg.sv]
// Purpose: Shared constants and types for the overvoltage and brownout supervisor.
// Assumes: 100 MHz core clock.
// Notes:   Analog thresholds arrive as comparator outputs; only timing is counted here.
package obp_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int OVP_BLANK_NS    = 2000;
	localparam int OVP_WIN_NS      = 500;
	localparam int OVP_BLANK_CYC   = (OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVP_WIN_CYC     = (OVP_WIN_NS / CLK_PERIOD_NS < 1) ? 1 :
		OVP_WIN_NS / CLK_PERIOD_NS;
	localparam int OVP_TRIP_COUNT  = 4;
	localparam int TIMER_W         = 12;
	localparam logic [TIMER_W-1:0] BLANK_LAST = TIMER_W'(OVP_BLANK_CYC - 1);
	localparam logic [TIMER_W-1:0] WIN_LAST   = TIMER_W'(OVP_BLANK_CYC + OVP_WIN_CYC - 1);
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 12'h000;
	localparam logic [2:0]         TRIP_LAST  = 3'(OVP_TRIP_COUNT);
	localparam logic [2:0]         TRIP_ZERO  = 3'h0;

	// ==========================================================
	// Supervisor states
	typedef enum logic [2:0] {
		OBP_WAIT_MAINS,
		OBP_RUN,
		OBP_OVP_OFF,
		OBP_LATCHED,
		OBP_BROWNOUT
	} obp_state_t;

	// ==========================================================
	// Sampling window phases
	typedef enum logic [1:0] {
		OBP_WIN_IDLE,
		OBP_WIN_BLANK,
		OBP_WIN_OPEN
	} obp_win_t;

endpackage : obp_pkg

// [obp_ovp_window.sv]
// Purpose: Sampling window after each switch turn-off and consecutive-trip counter.
// Assumes: switch_on_i is synchronous; comparator is valid in the off-time.
// Notes:   One evaluation per switching cycle, at the window close.
`timescale 1ns/1ps
module obp_ovp_window
	import obp_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	input  wire logic enable_i,
	input  wire logic switch_on_i,
	input  wire logic aux_ovp_i,
	output logic      trip_confirm_o,
	output logic      window_open_o
);

	obp_win_t         win_reg, win_next;
	logic [TIMER_W-1:0] tmr_reg, tmr_next;
	logic [2:0]       cnt_reg, cnt_next;
	logic             hit_reg, hit_next;
	logic             sw_d_reg;
	logic             off_edge;
	logic             closing;

	assign off_edge = sw_d_reg && !switch_on_i;
	assign closing  = (win_reg == OBP_WIN_OPEN) && (tmr_reg == WIN_LAST);

	// ==========================================================
	// Window and counter next state
	always_comb begin
		win_next = win_reg;
		tmr_next = tmr_reg;
		cnt_next = cnt_reg;
		hit_next = hit_reg;
		case (win_reg)
			OBP_WIN_IDLE: begin
				if (off_edge) begin
					win_next = OBP_WIN_BLANK;
					tmr_next = TIMER_ZERO;
					hit_next = 1'b0;
				end
			end
			OBP_WIN_BLANK: begin
				tmr_next = tmr_reg + 1'b1;
				if (tmr_reg == BLANK_LAST) begin
					win_next = OBP_WIN_OPEN;
				end
			end
			OBP_WIN_OPEN: begin
				tmr_next = tmr_reg + 1'b1;
				if (aux_ovp_i) begin
					hit_next = 1'b1;
				end
				if (closing) begin
					win_next = OBP_WIN_IDLE;
					if (hit_reg || aux_ovp_i) begin
						if (cnt_reg != TRIP_LAST) begin
							cnt_next = cnt_reg + 1'b1;
						end
					end else begin
						cnt_next = TRIP_ZERO;
					end
				end
			end
			default: win_next = OBP_WIN_IDLE;
		endcase
		if (switch_on_i && win_reg != OBP_WIN_IDLE) begin
			win_next = OBP_WIN_IDLE;
			cnt_next = TRIP_ZERO;
		end
		if (!enable_i) begin
			win_next = OBP_WIN_IDLE;
			cnt_next = TRIP_ZERO;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			win_reg  <= OBP_WIN_IDLE;
			tmr_reg  <= TIMER_ZERO;
			cnt_reg  <= TRIP_ZERO;
			hit_reg  <= 1'b0;
			sw_d_reg <= 1'b0;
		end else begin
			win_reg  <= win_next;
			tmr_reg  <= tmr_next;
			cnt_reg  <= cnt_next;
			hit_reg  <= hit_next;
			sw_d_reg <= switch_on_i;
		end
	end

	assign trip_confirm_o = (cnt_reg == TRIP_LAST);
	assign window_open_o  = (win_reg == OBP_WIN_OPEN);

	// ==========================================================
	// Checks
	trip_saturate_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		cnt_reg <= TRIP_LAST) else $error("trip counter over limit");
	window_blank_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(off_edge && win_reg == OBP_WIN_IDLE && enable_i) ##1 (!switch_on_i && enable_i) [*8]
		|-> !window_open_o) else $error("window opened inside blanking");
	miss_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(closing && !hit_reg && !aux_ovp_i) |=> cnt_reg == TRIP_ZERO)
		else $error("counter kept after a clean cycle");
	count_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(closing && aux_ovp_i && enable_i && !switch_on_i && cnt_reg < TRIP_LAST)
		|=> cnt_reg == $past(cnt_reg) + 3'h1) else $error("trip not counted");
	window_seen_c: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
		closing && hit_reg);

endmodule : obp_ovp_window

// [obp_supervisor.sv]
// Contract
// - In off-time, aux winding above 5V reference flags an overvoltage trip.
// - Trip accepted only in 0.5us window opening 2us after turn-off.
// - Overvoltage shutdown only after four consecutive tripped switching cycles.
// - Trip counter cleared in any cycle without a trip in its window.
// - Confirmed overvoltage stops switching and enables 1mA feedforward source.
// - Feedforward pin reaching 5V plus two Vbe with source on latches off.
// - Without latch threshold, overvoltage shutdown restarts after supply below 5V.
// - No start until mains sense above 0.485V; mains-fail held meanwhile.
// - Running, mains sense below 0.45V asserts mains-fail and shuts down.
// - Brownout opens pre-regulator switch, discharges soft-start, gate low.
// - Protection latch cleared when mains sense falls below 0.45V; the code clears it only once supply is also below restart.
// - Latched off, start-up generator cycles supply between start and start-0.5V.
// - In brownout start-up generator runs with no switching activity.
// - 15uA sink on mains sense whenever mains-fail is asserted.
// - Slope ramp output only during switch on-time when mode pin not at reference.
// - No slope ramp while the switch is off.
// - Latched-off state cleared by supply undervoltage lockout or by low mains with supply below restart.
// - Latched with low mains, start-up generator off until supply below restart.
//
// Purpose: Overvoltage and brownout supervisor for an offline converter controller.
// Assumes: All comparator inputs are synchronous digital levels from analog front ends.
// Notes:   Supply comparators (uvlo, below 5V, start, start-0.5V, restart) are inputs.
`timescale 1ns/1ps
module obp_supervisor
	import obp_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	input  wire logic uvlo_i,
	input  wire logic pwm_request_i,
	input  wire logic aux_winding_sense_ovp_i,
	input  wire logic feedforward_pin_latch_i,
	input  wire logic mains_sense_input_on_i,
	input  wire logic mains_sense_input_off_i,
	input  wire logic supply_below_5v_i,
	input  wire logic supply_above_start_i,
	input  wire logic supply_above_hyst_i,
	input  wire logic supply_above_restart_i,
	input  wire logic mode_slope_pin_at_ref_i,
	input  wire logic osc_ramp_i,
	output logic      gate_drive_o,
	output logic      ff_current_source_o,
	output logic      mains_fail_flag_o,
	output logic      mains_sink_o,
	output logic      pre_regulator_supply_switch_o,
	output logic      softstart_discharge_o,
	output logic      hv_startup_on_o,
	output logic      slope_ramp_o,
	output logic      latched_off_o
);

	// ==========================================================
	// Reset release
	logic rst_s1_reg, rst_s2_reg;
	logic rst_b;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	assign rst_b = rst_s2_reg;

	// ==========================================================
	// Overvoltage window and counter
	logic trip_confirm;
	logic window_open;
	logic run_en;

	obp_ovp_window u_ovp_window (
		.core_clk_i     (core_clk_i),
		.rst_b_i        (rst_b),
		.enable_i       (run_en),
		.switch_on_i    (gate_drive_o),
		.aux_ovp_i      (aux_winding_sense_ovp_i),
		.trip_confirm_o (trip_confirm),
		.window_open_o  (window_open)
	);

	// ==========================================================
	// Supervisor state machine
	obp_state_t state_reg, state_next;
	logic       hv_reg, hv_next;
	logic       hold_reg, hold_next;

	assign run_en = (state_reg == OBP_RUN);

	always_comb begin
		state_next = state_reg;
		hv_next    = hv_reg;
		hold_next  = hold_reg;
		case (state_reg)
			OBP_WAIT_MAINS: begin
				hv_next = 1'b1;
				if (mains_sense_input_on_i) begin
					state_next = OBP_RUN;
				end
			end
			OBP_RUN: begin
				hv_next = 1'b0;
				if (!mains_sense_input_off_i) begin
					state_next = OBP_BROWNOUT;
				end else if (trip_confirm) begin
					state_next = OBP_OVP_OFF;
				end
			end
			OBP_OVP_OFF: begin
				hv_next = 1'b0;
				if (feedforward_pin_latch_i) begin
					state_next = OBP_LATCHED;
					hold_next  = 1'b0;
				end else if (supply_below_5v_i) begin
					state_next = OBP_WAIT_MAINS;
				end
			end
			OBP_LATCHED: begin
				if (!mains_sense_input_off_i) begin
					hold_next = 1'b1;
				end
				// Act on low mains in the same cycle so the generator never pulses once
				if (hold_next) begin
					hv_next = 1'b0;
					if (!supply_above_restart_i) begin
						state_next = OBP_WAIT_MAINS;
						hold_next  = 1'b0;
					end
				end else if (!supply_above_hyst_i) begin
					hv_next = 1'b1;
				end else if (supply_above_start_i) begin
					hv_next = 1'b0;
				end
			end
			OBP_BROWNOUT: begin
				if (!supply_above_restart_i) begin
					hv_next = 1'b1;
				end else if (supply_above_start_i) begin
					hv_next = 1'b0;
				end
				if (mains_sense_input_on_i) begin
					state_next = OBP_RUN;
				end
			end
			default: state_next = OBP_WAIT_MAINS;
		endcase
		if (uvlo_i) begin
			state_next = OBP_WAIT_MAINS;
			hold_next  = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= OBP_WAIT_MAINS;
			hv_reg    <= 1'b0;
			hold_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			hv_reg    <= hv_next;
			hold_reg  <= hold_next;
		end
	end

	// ==========================================================
	// Output registers
	logic gate_next, ffsrc_next, fail_next, preg_next, ssd_next, ramp_next, latch_next;

	always_comb begin
		gate_next  = (state_next == OBP_RUN) && pwm_request_i;
		ffsrc_next = (state_next == OBP_OVP_OFF);
		fail_next  = (state_next == OBP_WAIT_MAINS && !mains_sense_input_on_i) ||
			(state_next == OBP_BROWNOUT);
		preg_next  = (state_next == OBP_RUN);
		ssd_next   = (state_next != OBP_RUN);
		ramp_next  = gate_next && !mode_slope_pin_at_ref_i && osc_ramp_i;
		latch_next = (state_next == OBP_LATCHED);
	end

	always_ff @(posedge core_clk_i or negedge rst_b) begin
		if (!rst_b) begin
			gate_drive_o                  <= 1'b0;
			ff_current_source_o           <= 1'b0;
			mains_fail_flag_o             <= 1'b1;
			mains_sink_o                  <= 1'b1;
			pre_regulator_supply_switch_o <= 1'b0;
			softstart_discharge_o         <= 1'b1;
			hv_startup_on_o               <= 1'b0;
			slope_ramp_o                  <= 1'b0;
			latched_off_o                 <= 1'b0;
		end else begin
			gate_drive_o                  <= gate_next;
			ff_current_source_o           <= ffsrc_next;
			mains_fail_flag_o             <= fail_next;
			mains_sink_o                  <= fail_next;
			pre_regulator_supply_switch_o <= preg_next;
			softstart_discharge_o         <= ssd_next;
			hv_startup_on_o               <= hv_next;
			slope_ramp_o                  <= ramp_next;
			latched_off_o                 <= latch_next;
		end
	end

	// ==========================================================
	// Checks
	sink_follows_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		mains_sink_o == mains_fail_flag_o)
		else $error("sink differs from fail flag");
	no_ramp_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		!gate_drive_o |-> !slope_ramp_o)
		else $error("ramp while switch off");
	mode_ref_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		mode_slope_pin_at_ref_i |=> !slope_ramp_o)
		else $error("ramp with mode at reference");

	// ==========================================================
	// Checks: mains and brownout
	start_block_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_WAIT_MAINS && !mains_sense_input_on_i) |=>
		!gate_drive_o)
		else $error("started without mains");
	mains_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_WAIT_MAINS && mains_sense_input_on_i && !uvlo_i) |=>
		(!mains_fail_flag_o && pre_regulator_supply_switch_o))
		else $error("mains good but no start");
	brown_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_RUN && !mains_sense_input_off_i) |=>
		(mains_fail_flag_o && !gate_drive_o && softstart_discharge_o &&
		!pre_regulator_supply_switch_o))
		else $error("brownout did not shut down");
	fail_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		mains_fail_flag_o |->
		!gate_drive_o)
		else $error("gate driven with mains failed");
	fail_preg_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		mains_fail_flag_o |->
		(!pre_regulator_supply_switch_o && softstart_discharge_o))
		else $error("supply switch closed with mains failed");
	brown_hv_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_BROWNOUT && !supply_above_restart_i) |=>
		hv_startup_on_o)
		else $error("generator off in brownout below restart");

	// ==========================================================
	// Checks: overvoltage and latch
	window_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		window_open |->
		!$past(gate_drive_o))
		else $error("window open in on-time");
	ovp_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_RUN && trip_confirm && mains_sense_input_off_i && !uvlo_i) |=>
		(ff_current_source_o && !gate_drive_o))
		else $error("overvoltage not acted on");
	ff_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		ff_current_source_o |->
		(!gate_drive_o && !latched_off_o))
		else $error("source on while switching or latched");
	ovp_restart_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_OVP_OFF && supply_below_5v_i && !feedforward_pin_latch_i) |=>
		state_reg == OBP_WAIT_MAINS)
		else $error("no restart after supply drop");
	latch_enter_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_OVP_OFF && feedforward_pin_latch_i && !uvlo_i) |=>
		latched_off_o)
		else $error("latch threshold ignored");
	latch_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_LATCHED && !uvlo_i && !hold_reg && mains_sense_input_off_i) |=>
		state_reg == OBP_LATCHED)
		else $error("latch left without cause");
	uvlo_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		uvlo_i |=>
		(!latched_off_o && !ff_current_source_o && !gate_drive_o))
		else $error("lockout did not clear protection");
	mains_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_LATCHED && hold_reg && !supply_above_restart_i) |=>
		!latched_off_o)
		else $error("latch kept after mains loss");

	// ==========================================================
	// Checks: start-up generator
	latch_cycle_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_LATCHED && !hold_reg && mains_sense_input_off_i &&
		!supply_above_hyst_i) |=> hv_startup_on_o)
		else $error("generator idle below hysteresis");
	latch_hv_a: assert property (@(posedge core_clk_i) disable iff (!rst_b)
		(state_reg == OBP_LATCHED && hold_reg) |=>
		!hv_startup_on_o)
		else $error("generator on with mains low");

	// ==========================================================
	// Coverage
	ovp_shut_c: cover property (@(posedge core_clk_i) disable iff (!rst_b)
		state_reg == OBP_RUN ##1 state_reg == OBP_OVP_OFF);
	latch_c: cover property (@(posedge core_clk_i) disable iff (!rst_b)
		state_reg == OBP_LATCHED && hold_reg);
	brown_c: cover property (@(posedge core_clk_i) disable iff (!rst_b)
		state_reg == OBP_BROWNOUT ##1 state_reg == OBP_RUN);
	latch_clear_c: cover property (@(posedge core_clk_i) disable iff (!rst_b)
		state_reg == OBP_LATCHED ##1 state_reg == OBP_WAIT_MAINS);

endmodule : obp_supervisor

// [obp_far_side.sv]
// Purpose: Far-side model: aux winding comparator and feedforward pin network.
// Assumes: Gate timing is seen from the registered gate drive output.
// Notes:   Trip mode 1 trips inside the sampling window, 2 inside the blanking time.
`timescale 1ns/1ps
module obp_far_side (
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       gate_i,
	input  wire logic       ff_source_i,
	input  wire logic [1:0] trip_mode_i,
	input  wire logic       latch_ok_i,
	output logic            aux_ovp_o,
	output logic            ff_latch_o
);
	logic [9:0] off_cnt_reg;
	logic [5:0] ff_cnt_reg;

	// ==========================================================
	// Off-time counter and comparator pulse
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			off_cnt_reg <= 10'h000;
			ff_cnt_reg  <= 6'h00;
		end else begin
			off_cnt_reg <= gate_i ? 10'h000 : off_cnt_reg + {9'h000, off_cnt_reg != 10'h3ff};
			ff_cnt_reg  <= (ff_source_i && latch_ok_i) ? ff_cnt_reg + {5'h00, ff_cnt_reg != 6'h3f}
				: 6'h00;
		end
	end

	// Trip only in off-time, so the comparator never fires while the switch conducts
	assign aux_ovp_o = !gate_i && ((trip_mode_i == 2'h1 && off_cnt_reg >= 10'h0d2 &&
		off_cnt_reg < 10'h0e6) || (trip_mode_i == 2'h2 && off_cnt_reg >= 10'h064 &&
		off_cnt_reg < 10'h078));
	// A high-impedance pin charges up to the latch level; a low one never gets there
	assign ff_latch_o = ff_cnt_reg >= 6'h14;
endmodule : obp_far_side

// [testbench.sv]
// Purpose: Self-checking bench for the overvoltage and brownout supervisor.
// Assumes: Mains comparator levels are driven directly; supply thresholds by the bench; aux and feedforward levels come from obp_far_side.
// Notes:   Expected values are queued by the driver and compared by a watcher.
`timescale 1ns/1ps
module testbench;
	import obp_pkg::*;
	typedef struct {int sel; logic exp;} obp_note_t;
	localparam int GATE = 0, FF = 1, FAIL = 2, SINK = 3, PREG = 4, SS = 5, HV = 6, RAMP = 7,
		LAT = 8;
	logic clk = 1'b0, rst_b = 1'b0, uvlo = 1'b0, pwm = 1'b0, aux, ffl;
	logic mon = 1'b0, moff = 1'b0, b5 = 1'b0, st = 1'b1, hy = 1'b1, rs = 1'b1;
	logic at_ref = 1'b0, osc = 1'b0, latch_ok = 1'b0;
	logic [1:0] trip_mode = 2'h0;
	logic [8:0] outs;
	obp_note_t  notes[$];
	obp_note_t  n;
	int         fail_count = 0, n_checks = 0, cyc = 0;

	initial begin
		forever #5 clk = ~clk;
	end

	obp_supervisor u_obp_supervisor (.core_clk_i(clk), .rst_b_i(rst_b), .uvlo_i(uvlo),
		.pwm_request_i(pwm), .aux_winding_sense_ovp_i(aux), .feedforward_pin_latch_i(ffl),
		.mains_sense_input_on_i(mon), .mains_sense_input_off_i(moff), .supply_below_5v_i(b5),
		.supply_above_start_i(st), .supply_above_hyst_i(hy), .supply_above_restart_i(rs),
		.mode_slope_pin_at_ref_i(at_ref), .osc_ramp_i(osc), .gate_drive_o(outs[0]),
		.ff_current_source_o(outs[1]), .mains_fail_flag_o(outs[2]), .mains_sink_o(outs[3]),
		.pre_regulator_supply_switch_o(outs[4]), .softstart_discharge_o(outs[5]),
		.hv_startup_on_o(outs[6]), .slope_ramp_o(outs[7]), .latched_off_o(outs[8]));

	obp_far_side u_obp_far_side (.core_clk_i(clk), .rst_b_i(rst_b), .gate_i(outs[0]),
		.ff_source_i(outs[1]), .trip_mode_i(trip_mode), .latch_ok_i(latch_ok),
		.aux_ovp_o(aux), .ff_latch_o(ffl));

	// ==========================================================
	// Reporting
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic check_bit(input int sel, input logic seen, input logic exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: output %0d is %b, wanted %b", $time, sel, seen, exp);
		end
	endtask : check_bit

	always @(negedge clk) begin
		while (notes.size() > 0) begin
			n = notes.pop_front();
			check_bit(n.sel, outs[n.sel], n.exp);
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			$display("unexpected at %0t: run did not finish", $time);
			tally_and_finish();
		end
	end

	// ==========================================================
	// Driver helpers
	task automatic ex(input int sel, input logic v);
		notes.push_back('{sel, v});
	endtask : ex

	task automatic settle(input int k);
		repeat (k) @(posedge clk);
	endtask : settle

	// One switching cycle: random on-time, then an off-time longer than blank plus window
	task automatic sw_cycle(input logic [1:0] m);
		int t;
		t = 20 + ($urandom % 40);
		trip_mode <= m;
		osc <= 1'($urandom);
		pwm <= 1'b1;
		settle(t);
		pwm <= 1'b0;
		settle(300);
	endtask : sw_cycle

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h845aeb2a));
		settle(4);
		rst_b <= 1'b1;
		pwm <= 1'b1;
		settle(20);
		ex(FAIL, 1'b1);
		ex(SINK, 1'b1);
		ex(PREG, 1'b0);
		ex(GATE, 1'b0);
		mon <= 1'b1;
		moff <= 1'b1;
		settle(5);
		ex(FAIL, 1'b0);
		ex(SINK, 1'b0);
		ex(PREG, 1'b1);
		ex(SS, 1'b0);
		ex(GATE, 1'b1);
		$display("test mains_start done");
		osc <= 1'b1;
		settle(3);
		ex(RAMP, 1'b1);
		at_ref <= 1'b1;
		settle(3);
		ex(RAMP, 1'b0);
		at_ref <= 1'b0;
		pwm <= 1'b0;
		settle(3);
		ex(RAMP, 1'b0);
		$display("test slope done");
		repeat (4) sw_cycle(2'h2);
		ex(FF, 1'b0);
		repeat (3) sw_cycle(2'h1);
		sw_cycle(2'h0);
		repeat (3) sw_cycle(2'h1);
		ex(FF, 1'b0);
		ex(GATE, 1'b0);
		sw_cycle(2'h1);
		pwm <= 1'b1;
		settle(3);
		ex(FF, 1'b1);
		ex(GATE, 1'b0);
		$display("test ovp_count done");
		b5 <= 1'b1;
		settle(3);
		b5 <= 1'b0;
		settle(6);
		ex(FF, 1'b0);
		ex(GATE, 1'b1);
		$display("test ovp_restart done");
		latch_ok <= 1'b1;
		repeat (4) sw_cycle(2'h1);
		settle(30);
		ex(LAT, 1'b1);
		st <= 1'b0;
		hy <= 1'b0;
		settle(3);
		ex(HV, 1'b1);
		st <= 1'b1;
		hy <= 1'b1;
		settle(3);
		ex(HV, 1'b0);
		b5 <= 1'b1;
		settle(3);
		ex(LAT, 1'b1);
		b5 <= 1'b0;
		mon <= 1'b0;
		moff <= 1'b0;
		hy <= 1'b0;
		settle(1);
		ex(HV, 1'b0);
		settle(2);
		ex(HV, 1'b0);
		rs <= 1'b0;
		settle(3);
		ex(LAT, 1'b0);
		ex(FAIL, 1'b1);
		$display("test latch_mains_clear done");
		mon <= 1'b1;
		moff <= 1'b1;
		rs <= 1'b1;
		hy <= 1'b1;
		settle(5);
		repeat (4) sw_cycle(2'h1);
		settle(30);
		ex(LAT, 1'b1);
		uvlo <= 1'b1;
		settle(3);
		ex(LAT, 1'b0);
		uvlo <= 1'b0;
		latch_ok <= 1'b0;
		trip_mode <= 2'h0;
		pwm <= 1'b1;
		settle(6);
		ex(GATE, 1'b1);
		$display("test uvlo_clear done");
		moff <= 1'b0;
		mon <= 1'b0;
		settle(3);
		ex(FAIL, 1'b1);
		ex(SINK, 1'b1);
		ex(PREG, 1'b0);
		ex(SS, 1'b1);
		ex(GATE, 1'b0);
		rs <= 1'b0;
		settle(2);
		ex(HV, 1'b1);
		rs <= 1'b1;
		settle(2);
		ex(HV, 1'b0);
		moff <= 1'b1;
		settle(4);
		ex(FAIL, 1'b1);
		ex(GATE, 1'b0);
		mon <= 1'b1;
		settle(3);
		ex(FAIL, 1'b0);
		ex(GATE, 1'b1);
		$display("test brownout done");
		settle(2);
		tally_and_finish();
	end
endmodule : testbench
